//--- verilog/ppb_map.svh
// register offsets, field positions, mode codes and timing for the push-button command block
`ifndef PPB_MAP_SVH
`define PPB_MAP_SVH

// ==================================================================
// register offsets and the read and reset byte values
`define PPB_ADDR_RESTART 8'h18
`define PPB_ADDR_POWER   8'h19
`define PPB_READ_BYTE    8'h00
`define PPB_RESET_BYTE   8'h00

// ==================================================================
// field positions (upper nibble / lower nibble of each command byte)
`define PPB_CLS_LSB      4
`define PPB_DET_LSB      0
`define PPB_OFF_LSB      4
`define PPB_ON_LSB       0

// ==================================================================
// per-channel operating mode codes
`define PPB_MODE_OFF     2'h0
`define PPB_MODE_MANUAL  2'h1
`define PPB_MODE_SEMI    2'h2
`define PPB_MODE_AUTO    2'h3

// ==================================================================
// class and fault codes
`define PPB_HI_CLASS     4'h5
`define PPB_INSUF_CODE   4'h1

// ==================================================================
// timing
`define PPB_CLK_MHZ      250
`define PPB_CLR_TIME_US  5000

`endif

//--- verilog/ppb_pkg.sv
// types shared by the push-button command block
`default_nettype none
package ppb_pkg;

  // ==================================================================
  // channel modes and sequencer states
  typedef logic [1:0] ppb_mode_type;

  typedef enum logic [1:0] {PPB_IDLE, PPB_WAIT_DET, PPB_WAIT_CLS} ppb_chan_st_type;

  // ==================================================================
  // top-level state
  typedef struct packed {
    logic [3:0] det_arm;
    logic [3:0] cls_arm;
    logic [7:0] rdata;
    logic       rd_valid;
    logic [3:0] fault_set;
    logic [3:0] fault_code;
  } ppb_top_state_type;

endpackage : ppb_pkg
`default_nettype wire

//--- verilog/ppb_chan.sv
// per-channel sequencer: deferred restarts, power-on attempts, power-off clear window
`timescale 1ns/1ps
`default_nettype none
`include "ppb_map.svh"
module ppb_chan #(
  parameter int CLR_CYCLES = `PPB_CLR_TIME_US * `PPB_CLK_MHZ,
  parameter int CW         = $clog2(CLR_CYCLES + 1)
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // configuration and engine status
  input  wire ppb_pkg::ppb_mode_type mode,
  input  wire logic             det_en,
  input  wire logic             cls_en,
  input  wire logic             cool,
  input  wire logic             disc,
  input  wire logic             alloc_ok,
  input  wire logic             det_done,
  input  wire logic             det_valid,
  input  wire logic             cls_done,
  input  wire logic             cls_valid,
  // qualified commands
  input  wire logic             r_det,
  input  wire logic             r_cls,
  input  wire logic             pwon,
  input  wire logic             pwoff,
  input  wire logic             direct,
  input  wire logic             direct_ok,
  // actions
  output logic                  det_start,
  output logic                  cls_start,
  output logic                  det_en_set,
  output logic                  cls_en_set,
  output logic                  power_on,
  output logic                  power_off,
  output logic                  clear,
  output logic                  busy
);

  typedef struct packed {
    ppb_pkg::ppb_chan_st_type st;
    logic          pend_det;
    logic          pend_cls;
    logic          alloc;
    logic          det_start;
    logic          cls_start;
    logic          det_en_set;
    logic          cls_en_set;
    logic          power_on;
    logic          power_off;
    logic          clear;
    logic [CW-1:0] cnt;
  } ppb_chan_state_type;

  ppb_chan_state_type s;
  ppb_chan_state_type next_s;

  localparam logic [CW-1:0] CLR_LOAD = CW'(CLR_CYCLES - 1);

  // ==================================================================
  // next state
  always_comb
  begin
    next_s            = s;
    next_s.det_start  = 1'b0;
    next_s.cls_start  = 1'b0;
    next_s.det_en_set = 1'b0;
    next_s.cls_en_set = 1'b0;
    next_s.power_on   = 1'b0;
    next_s.power_off  = 1'b0;
    next_s.clear      = 1'b0;
    if (s.cnt != '0)
    begin
      next_s.cnt = s.cnt - CW'(1);
    end
    // restarts are held while the channel cools down
    next_s.pend_det = s.pend_det | r_det; // R2 R5
    next_s.pend_cls = s.pend_cls | r_cls; // R2 R5
    if (!cool)
    begin
      if (next_s.pend_det)
      begin
        next_s.det_start  = (mode == `PPB_MODE_MANUAL); // R3
        next_s.det_en_set = (mode == `PPB_MODE_SEMI) || (mode == `PPB_MODE_AUTO); // R3
        next_s.pend_det   = 1'b0;
      end
      if (next_s.pend_cls)
      begin
        next_s.cls_start  = (mode == `PPB_MODE_MANUAL); // R3
        next_s.cls_en_set = (mode == `PPB_MODE_SEMI) || (mode == `PPB_MODE_AUTO); // R3
        next_s.pend_cls   = 1'b0;
      end
    end
    // sequencer for semi/auto turn-on attempts
    case (s.st)
      ppb_pkg::PPB_IDLE:
      begin
        // auto with both enables powers after every good cycle
        if ((mode == `PPB_MODE_AUTO) && det_en && cls_en && cls_done && cls_valid && alloc_ok)
        begin
          next_s.power_on = ~cool & ~disc; // R17
        end
      end
      ppb_pkg::PPB_WAIT_DET:
      begin
        if (cool || disc)
        begin
          next_s.st = ppb_pkg::PPB_IDLE; // R9
        end
        else if (det_done)
        begin
          next_s.cls_start = det_valid; // R16
          next_s.st        = det_valid ? ppb_pkg::PPB_WAIT_CLS : ppb_pkg::PPB_IDLE; // R14
        end
      end
      ppb_pkg::PPB_WAIT_CLS:
      begin
        if (cool || disc)
        begin
          next_s.st = ppb_pkg::PPB_IDLE; // R9
        end
        else if (cls_done)
        begin
          // single attempt: a bad result leaves the channel off until rewritten
          next_s.power_on = cls_valid & s.alloc; // R14 R15 R16
          next_s.st       = ppb_pkg::PPB_IDLE; // R14
        end
      end
      default:
      begin
        next_s.st = ppb_pkg::PPB_IDLE;
      end
    endcase
    // power-on command; cooling channels drop it outright
    if (pwon && !cool && !disc) // R9
    begin
      if (mode == `PPB_MODE_MANUAL)
      begin
        next_s.power_on = 1'b1; // R13
      end
      else if (direct)
      begin
        next_s.power_on = direct_ok; // R11 R12
      end
      else if (det_en && cls_en)
      begin
        if (mode == `PPB_MODE_SEMI)
        begin
          next_s.st    = ppb_pkg::PPB_WAIT_CLS; // R15
          next_s.alloc = alloc_ok; // R19
        end
      end
      else
      begin
        next_s.det_start = 1'b1; // R15 R16
        next_s.st        = ppb_pkg::PPB_WAIT_DET;
        next_s.alloc     = alloc_ok; // R19
      end
    end
    // power-off wins over power-on and the sequencer state and cancels pending work
    if (pwoff)
    begin
      next_s.st        = ppb_pkg::PPB_IDLE; // R20
      next_s.pend_det  = 1'b0;
      next_s.pend_cls  = 1'b0;
      next_s.power_on  = 1'b0; // R8
      next_s.power_off = 1'b1; // R20
      next_s.clear     = 1'b1; // R20
      next_s.cnt       = CLR_LOAD; // R21
    end
  end

  // ==================================================================
  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign det_start  = s.det_start;
  assign cls_start  = s.cls_start;
  assign det_en_set = s.det_en_set;
  assign cls_en_set = s.cls_en_set;
  assign power_on   = s.power_on;
  assign power_off  = s.power_off;
  assign clear      = s.clear;
  assign busy       = (s.cnt != '0); // clear window still open

  // ==================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_defer_cool: assert property (cool && !pwoff |=> !det_start && !det_en_set) // R5
    else $error("restart acted during cool-down");
  a_manual_launch: assert property (r_det && !cool && !pwoff && mode == `PPB_MODE_MANUAL
    |=> det_start) // R3
    else $error("manual restart did not launch detection");
  a_clear_window: assert property (power_off |-> clear ##1 busy[*3]) // R21
    else $error("power-off clear window missing");
  c_wait_cls: cover property (s.st == ppb_pkg::PPB_WAIT_CLS ##1 power_on);

endmodule : ppb_chan
`default_nettype wire

//--- verilog/ppb_cmd.sv
// push-button restart and power command decoder for one group of four channels
`timescale 1ns/1ps
`default_nettype none
`include "ppb_map.svh"
// Notes on behaviour
// [R1] restart byte: upper nibble restarts class, lower nibble detection, channel 4 first
// [R2] a one triggers the action; a zero leaves that event alone
// [R3] manual launches one cycle; semi-auto sets the channel's enable bit instead
// [R4] reading the restart register always returns zero
// [R5] restart during cool-down is kept and acted on once it ends
// [R6] paired 4-pair port in semi/auto needs both restart bits before enabling
// [R7] power byte: upper nibble off, lower nibble on; ignored in off mode
// [R8] on and off together for one channel turns it off
// [R9] cool-down and disconnect beat power-on; such a power-on is dropped
// [R10] lone power-on on high-class single-signature port fails with insufficient-power fault
// [R11] single-signature secondary powers at once if the primary is already on
// [R12] dual-signature second channel tries turn-on with allocation at command time
// [R13] manual mode power-on turns the channel on immediately
// [R14] semi-auto power-on makes one attempt; failure waits for a new command
// [R15] semi-auto: full cycle first unless both enables, then power after classification
// [R16] auto with an enable clear: one cycle, then power if valid and allocated
// [R17] auto with both enables powers automatically after each good cycle
// [R18] auto mode ignores a lone power-on on a 4-pair port
// [R19] host programs power allocation before power-on; later changes may be missed
// [R20] power-off disables the channel and clears only that channel's state
// [R21] power-off register clearing completes within about five milliseconds
// [R22] power-off of one channel of high-class single-signature port disables both
module ppb_cmd #(
  parameter int         CLR_CYCLES       = `PPB_CLR_TIME_US * `PPB_CLK_MHZ,
  parameter logic [3:0] INSUF_POWER_CODE = `PPB_INSUF_CODE
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // register port from the serial front end
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  output logic [7:0]       RDATA,
  output logic             RD_VALID,
  // per-channel and per-port configuration, two mode bits per channel
  input  wire logic [7:0]  MODE,
  input  wire logic [3:0]  DET_EN,
  input  wire logic [3:0]  CLS_EN,
  input  wire logic [1:0]  PAIR_4P,
  input  wire logic [1:0]  SINGLE_SIG,
  input  wire logic [15:0] ASSIGNED_CLASS,
  input  wire logic [3:0]  ALLOC_OK,
  // engine status
  input  wire logic [3:0]  COOLDOWN,
  input  wire logic [3:0]  DISCONNECT,
  input  wire logic [3:0]  POWERED,
  input  wire logic [3:0]  DET_DONE,
  input  wire logic [3:0]  DET_VALID,
  input  wire logic [3:0]  CLS_DONE,
  input  wire logic [3:0]  CLS_VALID,
  // actions towards the engines
  output logic [3:0]       DET_START,
  output logic [3:0]       CLS_START,
  output logic [3:0]       DET_EN_SET,
  output logic [3:0]       CLS_EN_SET,
  output logic [3:0]       POWER_ON,
  output logic [3:0]       POWER_OFF,
  output logic [3:0]       CLEAR_CHAN,
  output logic [3:0]       CLEAR_BUSY,
  // startup fault report
  output logic [3:0]       START_FAULT_SET,
  output logic [3:0]       START_FAULT_CODE
);

  ppb_pkg::ppb_top_state_type s;
  ppb_pkg::ppb_top_state_type next_s;

  logic [3:0] req_det;
  logic [3:0] req_cls;
  logic [3:0] req_on;
  logic [3:0] req_off;
  logic [3:0] req_direct;
  logic [3:0] req_direct_ok;

  // ==================================================================
  // helpers
  function automatic logic [1:0] mode_of(input logic [7:0] m, input int i);
    mode_of = m[2*i +: 2];
  endfunction : mode_of

  function automatic logic high_class(input logic [15:0] c, input int i);
    high_class = (c[4*i +: 4] >= `PPB_HI_CLASS);
  endfunction : high_class

  function automatic logic semi_or_auto(input logic [1:0] m);
    semi_or_auto = (m == `PPB_MODE_SEMI) || (m == `PPB_MODE_AUTO);
  endfunction : semi_or_auto

  // ==================================================================
  // command decode and pairing
  always_comb
  begin
    logic       wr_rst;
    logic       wr_pwr;
    logic [3:0] det_bits;
    logic [3:0] cls_bits;
    logic [3:0] on_bits;
    logic [3:0] off_bits;
    logic [3:0] off_req;
    logic [3:0] det_arm;
    logic [3:0] cls_arm;
    int         p;
    logic       four_p;
    logic       one_sig;
    logic [1:0] m;
    p             = 0;
    four_p        = 1'b0;
    one_sig       = 1'b0;
    m             = 2'h0;
    wr_rst        = WR_STB && (ADDR == `PPB_ADDR_RESTART);
    wr_pwr        = WR_STB && (ADDR == `PPB_ADDR_POWER);
    det_bits      = wr_rst ? WDATA[`PPB_DET_LSB +: 4] : 4'h0; // R1
    cls_bits      = wr_rst ? WDATA[`PPB_CLS_LSB +: 4] : 4'h0; // R1
    on_bits       = wr_pwr ? WDATA[`PPB_ON_LSB +: 4] : 4'h0; // R7
    off_bits      = wr_pwr ? WDATA[`PPB_OFF_LSB +: 4] : 4'h0; // R7
    off_req       = 4'h0;
    det_arm       = s.det_arm | det_bits;
    cls_arm       = s.cls_arm | cls_bits;
    next_s        = s;
    next_s.fault_set = 4'h0;
    req_det       = 4'h0;
    req_cls       = 4'h0;
    req_on        = 4'h0;
    req_off       = 4'h0;
    req_direct    = 4'h0;
    req_direct_ok = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (mode_of(MODE, i) != `PPB_MODE_OFF)
      begin
        off_req[i] = off_bits[i]; // R7
      end
    end
    for (int i = 0; i < 4; i++)
    begin
      p       = i ^ 1;
      m       = mode_of(MODE, i);
      four_p  = PAIR_4P[i/2];
      one_sig = four_p & SINGLE_SIG[i/2];
      // restart: paired ports collect both bits before anything is enabled
      if (four_p && semi_or_auto(m))
      begin
        req_det[i] = det_arm[i] & det_arm[p]; // R6
        req_cls[i] = cls_arm[i] & cls_arm[p]; // R6
      end
      else
      begin
        req_det[i] = det_bits[i]; // R2
        req_cls[i] = cls_bits[i]; // R2
      end
      // off: a high-class single-signature port goes down as a whole
      req_off[i] = off_req[i] | (one_sig & off_req[p] & high_class(ASSIGNED_CLASS, p)); // R20 R22
      // on: off in the same write wins
      if (on_bits[i] && (m != `PPB_MODE_OFF) && !req_off[i]) // R7 R8
      begin
        if (!four_p || on_bits[p] || (m == `PPB_MODE_MANUAL))
        begin
          req_on[i] = 1'b1; // R13
        end
        else if (m == `PPB_MODE_AUTO)
        begin
          req_on[i] = 1'b0; // R18
        end
        else if (POWERED[p])
        begin
          req_on[i]        = 1'b1;
          req_direct[i]    = 1'b1; // R11 R12
          req_direct_ok[i] = one_sig ? 1'b1 : ALLOC_OK[i]; // R11 R12
        end
        else if (one_sig && high_class(ASSIGNED_CLASS, i))
        begin
          next_s.fault_set[i] = 1'b1; // R10
          next_s.fault_code   = INSUF_POWER_CODE; // R10
        end
        else
        begin
          req_on[i] = 1'b1; // R10
        end
      end
    end
    // delivered or powered-off channels drop their half of a pair request
    for (int i = 0; i < 4; i++)
    begin
      next_s.det_arm[i] = (PAIR_4P[i/2] && semi_or_auto(mode_of(MODE, i)))
                          ? (det_arm[i] & ~req_det[i] & ~req_off[i]) : 1'b0; // R6
      next_s.cls_arm[i] = (PAIR_4P[i/2] && semi_or_auto(mode_of(MODE, i)))
                          ? (cls_arm[i] & ~req_cls[i] & ~req_off[i]) : 1'b0; // R6
    end
    // write-only registers answer every read with zero
    next_s.rd_valid = RD_STB;
    next_s.rdata    = `PPB_READ_BYTE; // R4
  end

  // ==================================================================
  // state register
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign RDATA            = s.rdata;
  assign RD_VALID         = s.rd_valid;
  assign START_FAULT_SET  = s.fault_set;
  assign START_FAULT_CODE = s.fault_code;

  // ==================================================================
  // channel sequencers
  for (genvar g = 0; g < 4; g++)
  begin : g_chan
    ppb_chan #(
      .CLR_CYCLES (CLR_CYCLES)
    ) u_chan (
      .clk        (CLK),
      .rst_n      (RST_N),
      .mode       (MODE[2*g +: 2]),
      .det_en     (DET_EN[g]),
      .cls_en     (CLS_EN[g]),
      .cool       (COOLDOWN[g]),
      .disc       (DISCONNECT[g]),
      .alloc_ok   (ALLOC_OK[g]),
      .det_done   (DET_DONE[g]),
      .det_valid  (DET_VALID[g]),
      .cls_done   (CLS_DONE[g]),
      .cls_valid  (CLS_VALID[g]),
      .r_det      (req_det[g]),
      .r_cls      (req_cls[g]),
      .pwon       (req_on[g]),
      .pwoff      (req_off[g]),
      .direct     (req_direct[g]),
      .direct_ok  (req_direct_ok[g]),
      .det_start  (DET_START[g]),
      .cls_start  (CLS_START[g]),
      .det_en_set (DET_EN_SET[g]),
      .cls_en_set (CLS_EN_SET[g]),
      .power_on   (POWER_ON[g]),
      .power_off  (POWER_OFF[g]),
      .clear      (CLEAR_CHAN[g]),
      .busy       (CLEAR_BUSY[g])
    );
  end

  // ==================================================================
  // checks on channel 0 and port 0-1
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_read_zero: assert property (RD_STB |=> RD_VALID && RDATA == 8'h00) // R4
    else $error("restart read returned nonzero");
  a_off_wins: assert property (WR_STB && ADDR == `PPB_ADDR_POWER && WDATA[4] && MODE[1:0] != 2'h0
    |=> POWER_OFF[0] && CLEAR_CHAN[0] && !POWER_ON[0]) // R8
    else $error("power-off with power-on did not turn channel off");
  a_off_mode: assert property (WR_STB && ADDR == `PPB_ADDR_POWER && MODE[1:0] == `PPB_MODE_OFF
    |=> !POWER_OFF[0]) // R7
    else $error("power command acted in off mode");
  a_manual_on: assert property (WR_STB && ADDR == `PPB_ADDR_POWER && WDATA[4:0] == 5'h01
    && MODE[1:0] == `PPB_MODE_MANUAL && !COOLDOWN[0] && !DISCONNECT[0] |=> POWER_ON[0]) // R13
    else $error("manual power-on not immediate");
  a_cool_drop: assert property (WR_STB && ADDR == `PPB_ADDR_POWER && WDATA[0] && COOLDOWN[0]
    && s.det_arm == 4'h0 |=> !POWER_ON[0] && !DET_START[0]) // R9
    else $error("power-on acted during cool-down");
  a_auto_single: assert property (WR_STB && ADDR == `PPB_ADDR_POWER && WDATA[5:0] == 6'h01
    && MODE[1:0] == `PPB_MODE_AUTO && PAIR_4P[0] |=> !DET_START[0] ##1 !DET_START[0]) // R18
    else $error("lone auto power-on on 4-pair port not ignored");
  a_insuf_fault: assert property (WR_STB && ADDR == `PPB_ADDR_POWER && WDATA[5:0] == 6'h01
    && MODE[1:0] == `PPB_MODE_SEMI && PAIR_4P[0] && SINGLE_SIG[0] && !POWERED[1]
    && ASSIGNED_CLASS[3:0] >= 4'h5 |=> START_FAULT_SET[0]
    && START_FAULT_CODE == INSUF_POWER_CODE && !DET_START[0]) // R10
    else $error("insufficient-power fault not raised");
  a_pair_off: assert property (WR_STB && ADDR == `PPB_ADDR_POWER && WDATA[4] && PAIR_4P[0]
    && SINGLE_SIG[0] && ASSIGNED_CLASS[3:0] >= 4'h5 && MODE[1:0] != 2'h0
    |=> POWER_OFF[1] && POWER_OFF[0]) // R22
    else $error("high-class single-signature port not fully disabled");

  a_direct_on: assert property (WR_STB && ADDR == `PPB_ADDR_POWER // R11
    && WDATA[5:0] == 6'h01 && MODE[1:0] == `PPB_MODE_SEMI
    && PAIR_4P[0] && SINGLE_SIG[0] && POWERED[1]
    && !COOLDOWN[0] && !DISCONNECT[0] |=> POWER_ON[0])
    else $error("secondary channel not powered at once");
  a_dual_alloc: assert property (WR_STB && ADDR == `PPB_ADDR_POWER // R12
    && WDATA[5:0] == 6'h01 && MODE[1:0] == `PPB_MODE_SEMI
    && PAIR_4P[0] && !SINGLE_SIG[0] && POWERED[1]
    && !ALLOC_OK[0] |=> !POWER_ON[0])
    else $error("turn-on ignored allocation");
  c_restart_semi: cover property (WR_STB && ADDR == `PPB_ADDR_RESTART ##1 DET_EN_SET[0]);
  c_power_off: cover property (POWER_OFF[0] ##1 CLEAR_BUSY[0]);
  c_fault: cover property (START_FAULT_SET != 4'h0);

endmodule : ppb_cmd
`default_nettype wire

//--- verilog/ppb_unused_placeholder_none.sv
// intentionally holds no design; pairing helper kept in main file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- test/ppb_host.sv
// host model that writes and reads the push-button command registers
`timescale 1ns/1ps
`default_nettype none
module ppb_host (
  // clock
  input  wire logic       clk,
  // register port towards the block
  output logic            wr_stb,
  output logic            rd_stb,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rd_valid
);
  // idle values from time zero
  initial
  begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr   = 8'h00;
    wdata  = 8'h00;
  end
  // one write, held across the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  // one read; the answer is registered, so it is taken one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    ok = rd_valid;
    d  = rdata;
  endtask : rd
endmodule : ppb_host
`default_nettype wire

//--- test/tb_ppb_cmd.sv
// self-checking bench for the push-button command block
`timescale 1ns/1ps
`default_nettype none
module tb_ppb_cmd;
  localparam int CLR = 16;
  logic        CLK, RST_N, WR_STB, RD_STB, RD_VALID, ok;
  logic [7:0]  ADDR, WDATA, RDATA, MODE, r, rb;
  logic [3:0]  DET_EN, CLS_EN, ALLOC_OK, COOLDOWN, DISCONNECT, POWERED;
  logic [3:0]  DET_DONE, DET_VALID, CLS_DONE, CLS_VALID;
  logic [3:0]  DET_START, CLS_START, DET_EN_SET, CLS_EN_SET, POWER_ON;
  logic [3:0]  POWER_OFF, CLEAR_CHAN, CLEAR_BUSY, START_FAULT_SET, START_FAULT_CODE;
  logic [1:0]  PAIR_4P, SINGLE_SIG;
  logic [15:0] ASSIGNED_CLASS;
  logic [31:0] seed;
  int          fails, checked, k;
  // ==================================================================
  // design and host
  ppb_cmd #(.CLR_CYCLES(CLR)) u_dut (.CLK(CLK), .RST_N(RST_N), .WR_STB(WR_STB),
    .RD_STB(RD_STB), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .RD_VALID(RD_VALID),
    .MODE(MODE), .DET_EN(DET_EN), .CLS_EN(CLS_EN), .PAIR_4P(PAIR_4P),
    .SINGLE_SIG(SINGLE_SIG), .ASSIGNED_CLASS(ASSIGNED_CLASS), .ALLOC_OK(ALLOC_OK),
    .COOLDOWN(COOLDOWN), .DISCONNECT(DISCONNECT), .POWERED(POWERED),
    .DET_DONE(DET_DONE), .DET_VALID(DET_VALID), .CLS_DONE(CLS_DONE),
    .CLS_VALID(CLS_VALID), .DET_START(DET_START), .CLS_START(CLS_START),
    .DET_EN_SET(DET_EN_SET), .CLS_EN_SET(CLS_EN_SET), .POWER_ON(POWER_ON),
    .POWER_OFF(POWER_OFF), .CLEAR_CHAN(CLEAR_CHAN), .CLEAR_BUSY(CLEAR_BUSY),
    .START_FAULT_SET(START_FAULT_SET), .START_FAULT_CODE(START_FAULT_CODE));
  ppb_host u_host (.clk(CLK), .wr_stb(WR_STB), .rd_stb(RD_STB), .addr(ADDR),
    .wdata(WDATA), .rdata(RDATA), .rd_valid(RD_VALID));
  // ==================================================================
  // helpers
  initial
  begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      $display("[ERR] %s exp=%h seen=%h", n, e, s);
      fails++;
    end
  endtask : chk
  task automatic results;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  // bounded wait on a channel-0 event or on all clear windows closing; running out fails the run
  task automatic await(input int b);
    logic [4:0] v;
    #1;
    for (k = 0; k < 40; k++)
    begin
      v = {~|CLEAR_BUSY, START_FAULT_SET[0], POWER_ON[0], CLS_START[0], DET_START[0]};
      if (v[b])
        return;
      @(posedge CLK);
      #1;
    end
    fails++;
    results();
  endtask : await
  // one detect and class result on channel 0
  task automatic walk(input logic cv);
    await(0);
    @(posedge CLK) {DET_DONE[0], DET_VALID[0]} <= 2'b11;
    @(posedge CLK) {DET_DONE[0], DET_VALID[0]} <= 2'b00;
    await(1);
    @(posedge CLK) {CLS_DONE[0], CLS_VALID[0]} <= {1'b1, cv};
    @(posedge CLK) {CLS_DONE[0], CLS_VALID[0]} <= 2'b00;
    #1;
  endtask : walk
  // ==================================================================
  // main sequence
  initial
  begin
    {RST_N, DET_EN, CLS_EN, COOLDOWN, DISCONNECT, POWERED, PAIR_4P, SINGLE_SIG} = '0;
    {DET_DONE, DET_VALID, CLS_DONE, CLS_VALID, ASSIGNED_CLASS} = '0;
    MODE = 8'h55;
    ALLOC_OK = 4'hf;
    seed = 32'h2df882ad;
    fails = 0;
    checked = 0;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    // manual mode: random restart and power bytes
    repeat (6)
    begin
      seed = lfsr(seed);
      r = seed[7:0];
      u_host.wr(8'h18, r);
      chk("det_start", DET_START, r[3:0]);
      chk("cls_start", CLS_START, r[7:4]);
      chk("det_en_set", DET_EN_SET, 4'h0);
      await(4);
      u_host.wr(8'h19, r);
      chk("power_on", POWER_ON, r[3:0] & ~r[7:4]);
      chk("power_off", POWER_OFF, r[7:4]);
      chk("clear_chan", CLEAR_CHAN, r[7:4]);
      await(4);
    end
    u_host.rd(8'h18, rb, ok);
    chk("rd_valid", ok, 1'b1);
    chk("rdata", rb, 8'h00);
    // clear window length after a lone power-off
    u_host.wr(8'h19, 8'h10);
    @(posedge CLK);
    #1;
    chk("clear_busy", CLEAR_BUSY, 4'h1);
    await(4);
    chk("clear_len", k <= CLR, 1'b1);
    // manual power-on is immediate; off mode ignores the power byte
    u_host.wr(8'h19, 8'h04);
    chk("power_on", POWER_ON, 4'h4);
    @(posedge CLK) MODE <= 8'h00;
    u_host.wr(8'h19, 8'hff);
    chk("off_mode", {POWER_ON, POWER_OFF}, 8'h00);
    // cool-down defers a restart and drops a power-on
    @(posedge CLK) {MODE, COOLDOWN, DISCONNECT} <= {8'h55, 4'h1, 4'h2};
    u_host.wr(8'h18, 8'h01);
    chk("det_start", DET_START, 4'h0);
    u_host.wr(8'h19, 8'h03);
    chk("power_on", POWER_ON, 4'h0);
    @(posedge CLK) {COOLDOWN, DISCONNECT} <= 8'h00;
    await(0);
    chk("power_on", POWER_ON, 4'h0);
    // semi-auto restarts set enables, paired ports need both halves
    @(posedge CLK) {MODE, PAIR_4P} <= {8'haa, 2'b01};
    u_host.wr(8'h18, 8'h01);
    chk("det_en_set", DET_EN_SET, 4'h0);
    u_host.wr(8'h18, 8'h02);
    chk("det_en_set", DET_EN_SET, 4'h3);
    @(posedge CLK) PAIR_4P <= 2'b00;
    u_host.wr(8'h18, 8'hff);
    chk("en_set", {CLS_EN_SET, DET_EN_SET, DET_START}, 12'hff0);
    // semi-auto one attempt: good cycle powers, bad class stays off
    u_host.wr(8'h19, 8'h01);
    walk(1'b1);
    chk("power_on", POWER_ON[0], 1'b1);
    u_host.wr(8'h19, 8'h01);
    walk(1'b0);
    chk("power_on", POWER_ON[0], 1'b0);
    // auto: command runs one cycle; both enables power with no command
    @(posedge CLK) MODE <= 8'hff;
    u_host.wr(8'h19, 8'h01);
    walk(1'b1);
    chk("power_on", POWER_ON[0], 1'b1);
    @(posedge CLK) {DET_EN[0], CLS_EN[0], CLS_DONE[0], CLS_VALID[0]} <= 4'hf;
    @(posedge CLK) {CLS_DONE[0], CLS_VALID[0]} <= 2'b00;
    #1;
    chk("auto_on", POWER_ON[0], 1'b1);
    // auto lone power-on on a 4-pair port is ignored
    @(posedge CLK) {DET_EN, CLS_EN, PAIR_4P} <= {8'h00, 2'b01};
    u_host.wr(8'h19, 8'h01);
    chk("lone_auto", {DET_START, POWER_ON}, 8'h00);
    // high-class single signature: lone on faults, lone off drops both
    @(posedge CLK) {MODE, SINGLE_SIG, ASSIGNED_CLASS} <= {8'haa, 2'b01, 16'h0055};
    u_host.wr(8'h19, 8'h01);
    await(3);
    chk("fault_set", START_FAULT_SET, 4'h1);
    chk("fault_code", START_FAULT_CODE, 4'h1);
    chk("power_on", POWER_ON, 4'h0);
    await(4);
    u_host.wr(8'h19, 8'h10);
    chk("power_off", POWER_OFF, 4'h3);
    @(posedge CLK) POWERED <= 4'h2;
    u_host.wr(8'h19, 8'h01);
    chk("direct_on", POWER_ON, 4'h1);
    @(posedge CLK) {SINGLE_SIG, ALLOC_OK} <= {2'b00, 4'he};
    u_host.wr(8'h19, 8'h01);
    chk("dual_on", POWER_ON, 4'h0);
    results();
  end
endmodule : tb_ppb_cmd
`default_nettype wire
